// [hdl/adr_control_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// two control registers of the audio processor, written over the serial control port
module adr_control_regs
  import adr_pkg::*;
#(
  parameter int SLOTS = SAFE_SLOTS_DEF           // safeload entries
)(
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     ctrl_latch_n,
  input  wire logic                     ctrl_clk,
  input  wire logic                     ctrl_din,
  output logic                          ctrl_dout,
  output logic                          ctrl_dout_oe,
  input  wire adr_serial_t              serial_source_zero,
  input  wire adr_serial_t              serial_source_one,
  input  wire adr_serial_t              serial_source_two,
  input  wire logic                     aux_deemph_pin,
  input  wire logic                     master_clock_source_zero,
  input  wire logic                     master_clock_source_one,
  input  wire logic                     master_clock_source_two,
  input  wire logic [SLOTS-1:0]         safeload_written,
  output logic [1:0]                    word_length,
  output logic [1:0]                    serial_format,
  output logic [1:0]                    deemph_select,
  output logic                          aux_input_enable,
  output logic                          capture_serial_out_pin_en,
  output logic                          core_clock_enable,
  output logic                          core_clock,
  output logic [GAIN_W-1:0]             ramp_gain,
  output logic                          safeload_copy_strobe,
  output logic [$clog2(SLOTS)-1:0]      safeload_copy_slot,
  output adr_serial_t                   serial_out,
  output logic                          serial_out_oe,
  output logic                          master_clock_output_pin,
  output logic                          master_clock_output_oe
);
  localparam int SLOT_W = $clog2(SLOTS);
  localparam int SYNC_W = 13;                    // 3 sources x 3, 3 master clocks, aux pin
  localparam int AUX_IDX = 12;

  typedef enum logic [1:0] {SL_IDLE, SL_WAIT, SL_COPY} adr_sl_state_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;                     // first sync stage
    logic [SYNC_W-1:0] sync;                     // second sync stage
    logic [MODE_W-1:0] mode;                     // audio_mode_and_core_control
    logic [CLK_W-1:0]  clks;                     // clock_and_source_select
    logic              frame_d;                  // last selected frame clock
    logic              mck_d;                    // last selected master clock
    logic              core_clk;                 // rebuilt core clock
    logic              div2;                     // core clock halved
    logic [GAIN_W-1:0] gain;                     // ramp volume
    logic              halted;                   // shutdown finished
    logic              safe_done;                // transfer finished, cleared on read
    adr_sl_state_t     sl;
    logic [SLOTS-1:0]  pend;                     // entries still to copy
    logic              copy_stb;
    logic [SLOT_W-1:0] copy_slot;
    logic [1:0]        deemph;
    logic              core_en;
    adr_serial_t       sout;
    logic              sout_oe;
    logic              mcko;
    logic              mcko_oe;
  } adr_state_t;

  adr_state_t                s_r;                // registered state
  adr_state_t                s_nxt;              // next state
  adr_spi_req_t              spi_req;            // finished control frames
  logic [SPI_DATA_BITS-1:0]  read_word;          // status readback
  adr_serial_t               src;                // selected serial source
  logic                      mck;                // selected master clock
  logic                      core_clk;
  logic                      frame_tick;         // one frame of the selected source
  logic                      wr_mode;
  logic                      wr_clk;
  logic                      rd_mode;
  logic                      safe_req;
  logic                      set_done;
  logic [GAIN_W-1:0]         step;
  logic [GAIN_W-1:0]         target;

  // serial source mux; the unused code gives a silent source
  function automatic adr_serial_t pick_src(input logic [1:0] sel, input logic [8:0] all);
    case (sel)
      2'h0:    pick_src = all[2:0];
      2'h1:    pick_src = all[5:3];
      2'h2:    pick_src = all[8:6];
      default: pick_src = '0;
    endcase
  endfunction

  // master clock mux, same code space as the serial mux
  function automatic logic pick_mck(input logic [1:0] sel, input logic [2:0] all);
    pick_mck = (sel == SEL_NONE) ? 1'b0 : all[sel];
  endfunction

  // lowest pending safeload slot
  function automatic logic [SLOT_W-1:0] lowest(input logic [SLOTS-1:0] pend);
    lowest = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        lowest = SLOT_W'(i);
      end
    end
  endfunction

  // serial control port
  adr_spi_port u_spi (
    .clock        (clock),
    .reset        (reset),
    .ctrl_latch_n (ctrl_latch_n),
    .ctrl_clk     (ctrl_clk),
    .ctrl_din     (ctrl_din),
    .read_word    (read_word),
    .ctrl_dout    (ctrl_dout),
    .ctrl_dout_oe (ctrl_dout_oe),
    .req          (spi_req)
  );

  // readback has only the two status flags; the clock register reads nothing
  assign read_word = {{(SPI_DATA_BITS-2){1'b0}}, s_r.halted, s_r.safe_done};

  // next-state logic
  always_comb begin
    s_nxt = s_r;
    // pins cross into the system clock through two flops
    s_nxt.meta = {aux_deemph_pin, master_clock_source_two, master_clock_source_one,
                  master_clock_source_zero, serial_source_two, serial_source_one, serial_source_zero};
    s_nxt.sync = s_r.meta;
    src = pick_src(s_r.clks[C_SRCSEL_LO +: 2], s_r.sync[8:0]);
    mck = pick_mck(s_r.clks[C_MCKSEL_LO +: 2], s_r.sync[11:9]);
    frame_tick = src.frame_clk & ~s_r.frame_d;
    s_nxt.frame_d = src.frame_clk;

    // register writes at 256 and 257
    wr_mode = spi_req.wr && spi_req.addr == ADDR_MODE_CTRL;
    wr_clk = spi_req.wr && spi_req.addr == ADDR_CLK_SEL;
    rd_mode = spi_req.rd_done && spi_req.addr == ADDR_MODE_CTRL;
    safe_req = wr_mode && spi_req.data[M_SAFE];
    if (wr_mode) begin
      // transfer bit is a command, never stored
      s_nxt.mode = spi_req.data[MODE_W-1:0] & ~(MODE_W'(1) << M_SAFE);
    end
    if (wr_clk) begin
      s_nxt.clks = spi_req.data[CLK_W-1:0] & ~(CLK_W'(1) << C_RSVD);
    end

    // core clock: straight or doubled from both input edges
    core_clk = s_r.clks[C_RATE] ? (mck ^ s_r.mck_d) : mck;
    s_nxt.mck_d = mck;
    s_nxt.core_clk = core_clk;
    if (core_clk && !s_r.core_clk) begin
      s_nxt.div2 = ~s_r.div2;
    end

    // master clock output mode
    case (s_r.clks[C_MCKO_LO +: 2])
      MCKO_OFF:  s_nxt.mcko = 1'b0;
      MCKO_CORE: s_nxt.mcko = core_clk;
      MCKO_HALF: s_nxt.mcko = ~s_r.div2;
      default:   s_nxt.mcko = mck;
    endcase
    s_nxt.mcko_oe = s_r.clks[C_MCKO_LO +: 2] != MCKO_OFF;

    // serial mux copy out, held low while disabled
    s_nxt.sout = s_r.clks[C_SOUT_EN] ? src : '0;
    s_nxt.sout_oe = s_r.clks[C_SOUT_EN];

    // the shared pin asks for 44.1 kHz only while it is not the aux input
    if (!s_r.mode[M_AUX] && s_r.sync[AUX_IDX]) begin
      s_nxt.deemph = DEEMPH_441;
    end else begin
      s_nxt.deemph = s_r.mode[M_DEEMPH_LO +: 2];
    end

    // volume ramp, one step per frame; mute and halt both aim at silence
    step = s_r.clks[C_RAMP_SLOW] ? STEP_SLOW : STEP_FAST;
    target = (s_r.mode[M_MUTE] || s_r.mode[M_HALT]) ? '0 : GAIN_UNITY;
    if (frame_tick) begin
      if (s_r.gain > target) begin
        s_nxt.gain = (s_r.gain - target > step) ? s_r.gain - step : target;
      end else if (s_r.gain < target) begin
        s_nxt.gain = (target - s_r.gain > step) ? s_r.gain + step : target;
      end
    end

    // core stops once the halt ramp has reached silence
    if (!s_r.mode[M_HALT]) begin
      s_nxt.halted = 1'b0;
    end else if (s_r.gain == '0) begin
      s_nxt.halted = 1'b1;
    end
    // clock gating only; no state is cleared by power-down or halt
    s_nxt.core_en = ~s_nxt.mode[M_PWRDN] & ~s_nxt.halted;

    // safeload copy waits for a frame boundary so the core is not disturbed
    set_done = 1'b0;
    s_nxt.copy_stb = 1'b0;
    unique case (s_r.sl)
      SL_IDLE: begin
        if (safe_req) begin
          s_nxt.pend = safeload_written;
          s_nxt.sl = SL_WAIT;
        end
      end
      SL_WAIT: begin
        if (frame_tick) begin
          s_nxt.sl = SL_COPY;
        end
      end
      SL_COPY: begin
        if (s_r.pend == '0) begin
          set_done = 1'b1;
          s_nxt.sl = SL_IDLE;
        end else begin
          s_nxt.copy_stb = 1'b1;
          s_nxt.copy_slot = lowest(s_r.pend);
          s_nxt.pend[lowest(s_r.pend)] = 1'b0;
        end
      end
    endcase
    // a finishing transfer wins over a read that clears in the same cycle
    s_nxt.safe_done = set_done | (s_r.safe_done & ~rd_mode);
  end

  // state register; only the reset pin clears it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.mode <= MODE_RESET;
      s_r.clks <= CLK_RESET;
      s_r.gain <= GAIN_UNITY;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state flops
  assign word_length = s_r.mode[M_WLEN_LO +: 2];
  assign serial_format = s_r.mode[M_FMT_LO +: 2];
  assign deemph_select = s_r.deemph;
  assign aux_input_enable = s_r.mode[M_AUX];
  assign capture_serial_out_pin_en = s_r.mode[M_CAPOUT];
  assign core_clock_enable = s_r.core_en;
  assign core_clock = s_r.core_clk;
  assign ramp_gain = s_r.gain;
  assign safeload_copy_strobe = s_r.copy_stb;
  assign safeload_copy_slot = s_r.copy_slot;
  assign serial_out = s_r.sout;
  assign serial_out_oe = s_r.sout_oe;
  assign master_clock_output_pin = s_r.mcko;
  assign master_clock_output_oe = s_r.mcko_oe;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence sl_copy_end;
    s_r.sl == SL_COPY && s_r.pend == '0;
  endsequence

  sequence halt_ramp_end;
    s_r.mode[M_HALT] && s_r.gain == '0;
  endsequence

  AST_WORD_LEN: assert property (wr_mode |=> word_length == $past(spi_req.data[1:0]))
    else $error("word length not taken from write");
  AST_FORMAT: assert property (wr_mode |=> serial_format == $past(spi_req.data[3:2]))
    else $error("serial format not taken from write");
  AST_DEEMPH_PIN: assert property (!s_r.mode[M_AUX] && s_r.sync[AUX_IDX] |=> deemph_select == DEEMPH_441)
    else $error("shared pin did not force 44.1 curve");
  AST_DEEMPH_REG: assert property (s_r.mode[M_AUX] |=> deemph_select == $past(s_r.mode[5:4]))
    else $error("de-emphasis field not applied");
  AST_PWRDN: assert property (s_r.mode[M_PWRDN] |-> !core_clock_enable)
    else $error("core clock running in power-down");
  AST_MUTE_STEP: assert property (frame_tick && s_r.mode[M_MUTE] && !s_r.clks[C_RAMP_SLOW]
                                  && s_r.gain >= STEP_FAST |=> ramp_gain == $past(s_r.gain) - STEP_FAST)
    else $error("mute ramp step wrong");
  AST_UNMUTE_STEP: assert property (frame_tick && !s_r.mode[M_MUTE] && !s_r.mode[M_HALT] && s_r.clks[C_RAMP_SLOW]
                                    && s_r.gain < GAIN_UNITY |=> ramp_gain == $past(s_r.gain) + STEP_SLOW)
    else $error("unmute ramp step wrong");
  AST_SAFE_DONE: assert property (sl_copy_end |=> s_r.safe_done ##0 s_r.sl == SL_IDLE)
    else $error("transfer done flag not set");
  AST_SAFE_CLEAR: assert property (rd_mode && !set_done |=> !s_r.safe_done)
    else $error("done flag survived its read");
  AST_HALT: assert property (halt_ramp_end |=> s_r.halted ##0 !core_clock_enable)
    else $error("core not stopped after halt ramp");
  AST_HALT_FLAG: assert property ($rose(s_r.halted) |-> $past(s_r.gain) == '0)
    else $error("shutdown flag before ramp end");
  AST_MCLK_OFF: assert property (s_r.clks[1:0] == MCKO_OFF |=> !master_clock_output_pin && !master_clock_output_oe)
    else $error("clock output active while off");
  AST_SOUT_OFF: assert property (!s_r.clks[C_SOUT_EN] |=> serial_out == '0 && !serial_out_oe)
    else $error("serial outputs driven while disabled");
  AST_RSVD: assert property (wr_clk |=> !s_r.clks[C_RSVD])
    else $error("reserved bit stored");
endmodule
`default_nettype wire

// [hdl/adr_spi_port.sv]
package adr_pkg;
  // serial control framing
  localparam int          ADDR_W        = 10;
  localparam int          SPI_DATA_BITS = 24;
  localparam int          SPI_FRAME_BITS = 40;
  localparam int          HDR_RW_POS    = 10;        // direction bit inside the 16-bit header
  localparam logic [5:0]  HDR_CNT       = 6'h10;     // header bits before data
  localparam logic [5:0]  FRAME_CNT     = 6'h28;     // bits in a complete register frame
  localparam logic [5:0]  CNT_SAT       = 6'h3F;     // counter stops here on long frames
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL = 10'h100;  // 256
  localparam logic [ADDR_W-1:0] ADDR_CLK_SEL   = 10'h101;  // 257
  // audio_mode_and_core_control fields
  localparam int          MODE_W        = 12;
  localparam int          M_WLEN_LO     = 0;
  localparam int          M_FMT_LO      = 2;
  localparam int          M_DEEMPH_LO   = 4;
  localparam int          M_PWRDN       = 6;
  localparam int          M_MUTE        = 7;
  localparam int          M_CAPOUT      = 8;
  localparam int          M_SAFE        = 9;
  localparam int          M_HALT        = 10;
  localparam int          M_AUX         = 11;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
  localparam int          RD_SAFE_DONE  = 0;
  localparam int          RD_HALT_DONE  = 1;
  localparam logic [1:0]  DEEMPH_441    = 2'h1;
  // clock_and_source_select fields
  localparam int          CLK_W         = 10;
  localparam int          C_MCKO_LO     = 0;
  localparam int          C_RATE        = 2;
  localparam int          C_RSVD        = 3;
  localparam int          C_MCKSEL_LO   = 4;
  localparam int          C_SRCSEL_LO   = 6;
  localparam int          C_SOUT_EN     = 8;
  localparam int          C_RAMP_SLOW   = 9;
  localparam logic [CLK_W-1:0] CLK_RESET = 10'h000;
  localparam logic [1:0]  MCKO_OFF      = 2'h0;
  localparam logic [1:0]  MCKO_CORE     = 2'h1;
  localparam logic [1:0]  MCKO_HALF     = 2'h2;
  localparam logic [1:0]  MCKO_THRU     = 2'h3;
  localparam logic [1:0]  SEL_NONE      = 2'h3;
  // volume ramp: full scale 8192 units, unity half of it
  localparam int          GAIN_W        = 14;
  localparam logic [GAIN_W-1:0] GAIN_FULL  = 14'h2000;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 14'h1000;
  localparam logic [GAIN_W-1:0] STEP_FAST  = 14'h0008;  // full scale in 1024 frames
  localparam logic [GAIN_W-1:0] STEP_SLOW  = 14'h0001;  // full scale in 8192 frames
  localparam int          SAFE_SLOTS_DEF = 5;

  // one serial audio source: data, frame clock, bit clock
  typedef struct packed {
    logic data;
    logic frame_clk;
    logic bit_clk;
  } adr_serial_t;

  // decoded serial control frame
  typedef struct packed {
    logic                     wr;       // write frame finished
    logic                     rd_done;  // read frame finished
    logic [ADDR_W-1:0]        addr;
    logic [SPI_DATA_BITS-1:0] data;
  } adr_spi_req_t;
endpackage

`timescale 1ns/10ps
`default_nettype none
// serial control port: oversamples the host pins on the system clock
module adr_spi_port
  import adr_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     ctrl_latch_n,
  input  wire logic                     ctrl_clk,
  input  wire logic                     ctrl_din,
  input  wire logic [SPI_DATA_BITS-1:0] read_word,
  output logic                          ctrl_dout,
  output logic                          ctrl_dout_oe,
  output adr_spi_req_t                  req
);
  typedef struct packed {
    logic [2:0]                meta;     // first sync stage, read only by sync
    logic [2:0]                sync;     // latch, clock, data
    logic                      clk_d;    // previous synced clock for edges
    logic [5:0]                bit_cnt;
    logic [SPI_FRAME_BITS-1:0] shin;
    logic [SPI_DATA_BITS-1:0]  shout;
    logic                      dout;
    logic                      oe;
    adr_spi_req_t              req;
  } adr_spi_state_t;

  adr_spi_state_t            s_r;        // registered state
  adr_spi_state_t            s_nxt;      // next state
  logic                      rise;
  logic                      fall;
  logic [SPI_FRAME_BITS-1:0] shin_nxt;

  // frame decode; pins are only a few system cycles late, fine at an 80 ns link clock
  always_comb begin
    s_nxt = s_r;
    rise = s_r.sync[1] & ~s_r.clk_d;
    fall = ~s_r.sync[1] & s_r.clk_d;
    shin_nxt = {s_r.shin[SPI_FRAME_BITS-2:0], s_r.sync[0]};
    s_nxt.meta = {ctrl_latch_n, ctrl_clk, ctrl_din};
    s_nxt.sync = s_r.meta;
    s_nxt.clk_d = s_r.sync[1];
    s_nxt.req.wr = 1'b0;
    s_nxt.req.rd_done = 1'b0;
    if (s_r.sync[2]) begin
      // latch high: frame over, only exact-length frames count
      if (s_r.bit_cnt == FRAME_CNT) begin
        s_nxt.req.addr = s_r.shin[SPI_DATA_BITS +: ADDR_W];
        s_nxt.req.data = s_r.shin[SPI_DATA_BITS-1:0];
        s_nxt.req.wr = ~s_r.shin[SPI_DATA_BITS + HDR_RW_POS];
        s_nxt.req.rd_done = s_r.shin[SPI_DATA_BITS + HDR_RW_POS];
      end
      s_nxt.bit_cnt = '0;
      s_nxt.oe = 1'b0;
      s_nxt.dout = 1'b0;
    end else if (rise) begin
      // sample on the rising link clock edge
      s_nxt.shin = shin_nxt;
      if (s_r.bit_cnt != CNT_SAT) begin
        s_nxt.bit_cnt = s_r.bit_cnt + 6'h01;
      end
      if (s_r.bit_cnt + 6'h01 == HDR_CNT && shin_nxt[HDR_RW_POS]) begin
        // read: drive from the start of the first data byte
        s_nxt.shout = (shin_nxt[ADDR_W-1:0] == ADDR_MODE_CTRL) ? read_word : '0;
        s_nxt.dout = (shin_nxt[ADDR_W-1:0] == ADDR_MODE_CTRL) ? read_word[SPI_DATA_BITS-1] : 1'b0;
        s_nxt.oe = 1'b1;
      end
    end else if (fall && s_r.oe && s_r.bit_cnt > HDR_CNT) begin
      // next bit on the falling edge so the host sees it settled
      s_nxt.shout = {s_r.shout[SPI_DATA_BITS-2:0], 1'b0};
      s_nxt.dout = s_r.shout[SPI_DATA_BITS-2];
    end
  end

  // state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      // latch stages idle high like the pin, so reset looks like no frame
      s_r.meta[2] <= 1'b1;
      s_r.sync[2] <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign ctrl_dout = s_r.dout;
  assign ctrl_dout_oe = s_r.oe;
  assign req = s_r.req;
endmodule
`default_nettype wire

// [test/adr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// serial control host: 16 header bits then 24 data bits, msb first
module adr_host_model
  import adr_pkg::*;
(
  input  wire logic clock,
  input  wire logic ctrl_dout,
  output logic      ctrl_latch_n,
  output logic      ctrl_clk,
  output logic      ctrl_din
);
  logic [39:0] sh;  // frame being shifted out
  initial begin
    ctrl_latch_n = 1'b1;
    ctrl_clk = 1'b0;
    ctrl_din = 1'b0;
  end
  // link clock only runs inside a frame, 80 ns period
  task automatic frame(input logic rw, input logic [9:0] a, input logic [23:0] wd, output logic [23:0] rdat);
    sh = {5'h00, rw, a, wd};
    rdat = 24'h000000;
    @(negedge clock) ctrl_latch_n <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      ctrl_din <= sh[39-i];
      repeat (4) @(negedge clock);
      ctrl_clk <= 1'b1;
      repeat (4) @(negedge clock);
      // sample late in the high phase, the port answers after sync delay
      if (i >= 16) rdat = {rdat[22:0], ctrl_dout};
      ctrl_clk <= 1'b0;
    end
    ctrl_din <= ~ctrl_din;  // no stale level after the frame
    repeat (4) @(negedge clock);
    ctrl_latch_n <= 1'b1;
    repeat (8) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// [test/tb_adr_control_regs.sv]
`timescale 1ns/10ps
`default_nettype none
// control register bench: host frames in, decoded fields and flags out
module tb_adr_control_regs
  import adr_pkg::*;
;
  logic              clock, reset, latch_n, lclk, din, dout, dout_oe, aux_pin, mclk, aux_en, cap_en;
  logic              core_en, core_clk, strobe, sout_oe, mco, mco_oe;
  logic [1:0]        wlen, fmt, demph, k;
  logic [2:0]        slot, fc;
  logic [2:0]        m, sd;     // clock out and serial out samples
  logic [4:0]        written;
  logic [GAIN_W-1:0] gain;
  logic [23:0]       rd;
  logic [2:0]        slots[$];  // copy slots in strobe order
  adr_serial_t       src0, srcx, sout;
  int                bad_count, num_checks, n;
  adr_host_model adr_host_model_inst (.clock(clock), .ctrl_dout(dout), .ctrl_latch_n(latch_n), .ctrl_clk(lclk),
    .ctrl_din(din));
  adr_control_regs adr_control_regs_inst (.clock(clock), .reset(reset), .ctrl_latch_n(latch_n), .ctrl_clk(lclk),
    .ctrl_din(din), .ctrl_dout(dout), .ctrl_dout_oe(dout_oe), .serial_source_zero(src0), .serial_source_one(srcx),
    .serial_source_two(srcx), .aux_deemph_pin(aux_pin), .master_clock_source_zero(mclk),
    .master_clock_source_one(1'b0), .master_clock_source_two(1'b0), .safeload_written(written), .word_length(wlen),
    .serial_format(fmt), .deemph_select(demph), .aux_input_enable(aux_en), .capture_serial_out_pin_en(cap_en),
    .core_clock_enable(core_en), .core_clock(core_clk), .ramp_gain(gain), .safeload_copy_strobe(strobe),
    .safeload_copy_slot(slot), .serial_out(sout), .serial_out_oe(sout_oe), .master_clock_output_pin(mco),
    .master_clock_output_oe(mco_oe));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // frame clock every 8 cycles, master clock every 2
  always @(negedge clock) begin
    mclk <= ~mclk;
    fc <= fc + 3'h1;
    src0 <= {~src0.data, fc[2], fc[0]};
  end
  // log every copy strobe
  always @(posedge clock) begin
    if (strobe === 1'b1) slots.push_back(slot);
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [23:0] d);
    adr_host_model_inst.frame(1'b0, a, d, rd);
  endtask
  // read frame, then the output driver must be released
  task automatic rdc(input logic [9:0] a, input logic [23:0] exp);
    adr_host_model_inst.frame(1'b1, a, 24'h000000, rd);
    check({rd[22:0], dout_oe}, {exp[22:0], 1'b0});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard, about twice the expected run
  initial begin
    repeat (30000) @(posedge clock);
    bad_count++;
    print_verdict();
  end
  initial begin
    reset = 1'b1;
    {mclk, aux_pin, written, fc, src0, srcx} = '0;
    bad_count = 0;
    num_checks = 0;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (4) @(negedge clock);
    check(24'(gain), 24'(GAIN_UNITY));
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      aux_pin <= (i == 2);
      wr(ADDR_MODE_CTRL, 24'({k[0], 2'b00, k[0], 1'b0, k[1], k, k, k}));
      check(24'({wlen, fmt, demph, aux_en, cap_en, core_en}), 24'({k, k, ((i == 2) ? 2'h1 : k), k[0], k[0], ~k[1]}));
    end
    $display("test mode fields done");
    // reserved bit held high throughout
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CLK_SEL, 24'h000108 | 24'(i));
      for (int j = 0; j < 3; j++) begin
        @(negedge clock);
        m[j] = mco;
        sd[j] = sout.data;
      end
      check(24'({sout_oe, mco_oe, m[0] ^ m[2], ((i == 0) ? (|m) : ((m[0] ^ m[1]) | (m[1] ^ m[2]))),
        sd[0] ^ sd[1]}), 24'({1'b1, i != 0, i == 2, i != 0, 1'b1}));
    end
    // source one is tied low: both muxes must follow it
    wr(ADDR_CLK_SEL, 24'h000153);
    for (int j = 0; j < 3; j++) begin
      @(negedge clock);
      m[j] = mco;
      sd[j] = sout.data;
    end
    check(24'({m, sd}), 24'h000000);
    wr(ADDR_CLK_SEL, 24'h000103);
    rdc(ADDR_CLK_SEL, 24'h000000);
    $display("test clock select done");
    written = 5'h05;
    wr(ADDR_MODE_CTRL, 24'h000200);
    rdc(ADDR_MODE_CTRL, 24'h000001);
    check(24'({slots[0], slots[1], 3'(slots.size())}), 24'h000012);
    rdc(ADDR_MODE_CTRL, 24'h000000);
    $display("test safe transfer done");
    wr(ADDR_MODE_CTRL, 24'h000400);
    n = 0;
    while (core_en !== 1'b0 && n < 6000) begin
      @(negedge clock);
      n++;
    end
    check(24'({gain, n > 4060 && n < 4130}), 24'({14'h0000, 1'b1}));
    rdc(ADDR_MODE_CTRL, 24'h000002);
    wr(ADDR_MODE_CTRL, 24'h000000);
    check(24'(core_en), 24'h000001);
    repeat (4200) @(negedge clock);
    check(24'(gain), 24'(GAIN_UNITY));
    $display("test halt and restart done");
    // soft mute at the fast ramp, then back up
    wr(ADDR_MODE_CTRL, 24'h000080);
    repeat (80) @(negedge clock);
    check(24'(gain < GAIN_UNITY - 14'h0040 && gain > GAIN_UNITY - 14'h0060), 24'h000001);
    wr(ADDR_MODE_CTRL, 24'h000000);
    repeat (600) @(negedge clock);
    check(24'(gain), 24'(GAIN_UNITY));
    // slow ramp: one unit per frame
    wr(ADDR_CLK_SEL, 24'h000200);
    wr(ADDR_MODE_CTRL, 24'h000080);
    wr(ADDR_MODE_CTRL, 24'h000000);
    check(24'(gain < GAIN_UNITY && gain > GAIN_UNITY - 14'h0040), 24'h000001);
    repeat (600) @(negedge clock);
    check(24'(gain), 24'(GAIN_UNITY));
    $display("test mute ramps done");
    print_verdict();
  end
endmodule
`default_nettype wire
